//--- dv/lmr_panel_model.sv
// Passive panel: notes which elements of columns 0-7 light up
`timescale 1ns/100ps
module lmr_panel_model
    import lmr_pkg::*;
(
    input wire logic mclk,
    input wire logic clear,
    input wire lmr_pkg::lmr_bp_s bp,
    input wire logic [15:0] seg,
    output logic [3:0][7:0] lit
);
    // Lit only when backplane at a rail and segment at the opposite one
    always_ff @(posedge mclk) begin
        for (int r = 0; r < 4; r++) begin
            for (int c = 0; c < 8; c++) begin
                if (clear) lit[r][c] <= 1'b0;
                else if (bp[2*r+:2] inside {2'h0, 2'h3} &&
                    seg[2*c+:2] == ~bp[2*r+:2]) lit[r][c] <= 1'b1;
            end
        end
    end
endmodule : lmr_panel_model

//--- dv/lmr_ram_mapper_properties.sv
// Port assertions for the display memory mapper
`timescale 1ns/100ps
module lmr_ram_mapper_properties
    import lmr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire lmr_pkg::lmr_cfg_s cfgIn,
    input wire logic cfgLoad,
    input wire logic dataValid,
    input wire logic [lmr_pkg::PTR_W-1:0] ptrIn,
    input wire logic ptrLoad,
    input wire lmr_pkg::lmr_bp_s backplane_out_top,
    input wire lmr_pkg::lmr_bp_s backplane_out_bot,
    input wire logic [lmr_pkg::COLS*lmr_pkg::LVL_W-1:0] segment_outputs,
    input wire logic biasBypass,
    input wire logic [lmr_pkg::PTR_W-1:0] dataPtr
);
    lmr_cfg_s cfg, next_cfg;
    logic [7:0] step;
    wire lmr_bp_s b = backplane_out_top;
    always_comb begin
        next_cfg = cfgLoad ? cfgIn : cfg;
        case (cfg.mode)
            MODE_STATIC: step = 8'h08;
            MODE_MUX2: step = 8'h04;
            MODE_MUX3: step = 8'h03;
            default: step = 8'h02;
        endcase
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) cfg <= CFG_RESET;
        else cfg <= next_cfg;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Outputs trail a config load by one cycle, so wait two
    sequence settled(lmr_mode_e m);
        cfg.mode == m && cfg == $past(cfg) && cfg == $past(cfg, 2);
    endsequence
    sequence byteTaken;
        dataValid && !ptrLoad;
    endsequence
    bp_rows_a: assert property (b == backplane_out_bot)
        else $error("backplane rows differ");
    ptr_step_a: assert property (byteTaken |=>
        dataPtr == 8'($past(dataPtr) + $past(step)))
        else $error("pointer step wrong");
    ptr_load_a: assert property (ptrLoad |=> dataPtr == $past(ptrIn))
        else $error("pointer load wrong");
    static_bp_a: assert property (settled(MODE_STATIC) |->
        b.bp0 == b.bp1 && b.bp1 == b.bp2 && b.bp2 == b.bp3)
        else $error("static backplanes differ");
    mux2_bp_a: assert property (settled(MODE_MUX2) |->
        b.bp2 == b.bp0 && b.bp3 == b.bp1)
        else $error("two-way backplane copy wrong");
    mux3_bp_a: assert property (settled(MODE_MUX3) |-> b.bp3 == b.bp1)
        else $error("three-way backplane copy wrong");
    bias_bypass_a: assert property ($stable(cfg) && cfg == $past(cfg, 2)
        |-> biasBypass == (cfg.mode == MODE_MUX2 && cfg.halfBias))
        else $error("divider bypass wrong");
    static_level_a: assert property (settled(MODE_STATIC) |->
        segment_outputs[1:0] inside {2'h0, 2'h3} && b.bp0 inside {2'h0, 2'h3})
        else $error("static drive not two-level");
endmodule : lmr_ram_mapper_properties
bind lmr_ram_mapper lmr_ram_mapper_properties chk (.mclk, .rst, .cfgIn,
    .cfgLoad, .dataValid, .ptrIn, .ptrLoad, .backplane_out_top,
    .backplane_out_bot, .segment_outputs, .biasBypass, .dataPtr);

//--- dv/lmr_ram_mapper_test.sv
// Self-checking bench for the display memory mapper
`timescale 1ns/100ps
module lmr_ram_mapper_test;
    import lmr_pkg::*;
    logic mclk = 0, rst = 1, clkTick = 0, cfgLoad = 0, dataValid = 0;
    logic ptrLoad = 0, clear = 0;
    lmr_cfg_s cfgIn = CFG_RESET;
    logic [7:0] dataByte = 8'h00, ptrIn = 8'h00, ptr, stepV, dataPtr;
    lmr_bp_s bpTop;
    logic [COLS*LVL_W-1:0] seg;
    logic [3:0][7:0] lit;
    logic [31:0] mask;
    logic [7:0] ptrQ [$];
    logic [31:0] litQ [$];
    int mismatches = 0, n_compared = 0;
    event scanDone;
    always #20 mclk = ~mclk;
    always @(posedge mclk) clkTick <= ~clkTick;
    lmr_ram_mapper uut (.mclk(mclk), .rst(rst), .clkTick(clkTick),
        .cfgIn(cfgIn), .cfgLoad(cfgLoad), .dataByte(dataByte),
        .dataValid(dataValid), .ptrIn(ptrIn), .ptrLoad(ptrLoad),
        .backplane_out_top(bpTop), .backplane_out_bot(),
        .segment_outputs(seg), .biasBypass(), .dataPtr(dataPtr));
    lmr_panel_model panel (.mclk(mclk), .clear(clear), .bp(bpTop),
        .seg(seg[15:0]), .lit(lit));
    task automatic check_ptr(input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value dataPtr expected %h seen %h", e, g);
        end
    endtask : check_ptr
    task automatic check_lit(input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value lit expected %h seen %h", e, g);
        end
    endtask : check_lit
    always @(posedge mclk) begin
        if (!rst && (dataValid || ptrLoad)) begin
            #1 check_ptr(ptrQ.pop_front(), dataPtr);
        end
    end
    always @(scanDone) check_lit(litQ.pop_front(), lit & mask);
    task automatic drive(input logic ld, input logic dv, input logic [7:0] v);
        @(posedge mclk);
        ptrLoad <= ld;
        dataValid <= dv;
        ptrIn <= v;
        dataByte <= v;
        ptr = ld ? v : ptr + stepV;
        ptrQ.push_back(ptr);
    endtask : drive
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #200us;
        mismatches++;
        test_done();
    end
    initial begin
        logic [7:0] b;
        logic [31:0] e;
        int col;
        int md;
        void'($urandom(50580));
        for (int m = 0; m < 8; m++) begin
            md = m % 4;
            rst <= 1'b1;
            repeat (10) @(posedge mclk);
            rst <= 1'b0;
            ptr = 8'h00;
            stepV = md == 0 ? 8'h08 : md == 1 ? 8'h04 : md == 2 ? 8'h03 : 8'h02;
            mask = ~(32'hffffffff << (8 * (md + 1)));
            @(posedge mclk);
            // Every mode with third bias first, then with half bias
            cfgIn <= '{mode: lmr_mode_e'(md), halfBias: m >= 4};
            cfgLoad <= 1'b1;
            @(posedge mclk);
            cfgLoad <= 1'b0;
            drive(1'b1, 1'b0, 8'h00);
            e = '0;
            for (int n = 0; n < 4; n++) begin
                b = 8'($urandom());
                for (int i = 0; i < 8; i++) begin
                    col = n * stepV + i / (md + 1);
                    if (col < 8) e[(i % (md + 1)) * 8 + col] = b[7-i];
                end
                drive(1'b0, 1'b1, b);
            end
            litQ.push_back(e);
            @(posedge mclk);
            dataValid <= 1'b0;
            clear <= 1'b1;
            @(posedge mclk);
            clear <= 1'b0;
            repeat (150) @(posedge mclk);
            -> scanDone;
        end
        // Load wins over a byte, then the pointer wraps past 8 bits
        drive(1'b1, 1'b1, 8'hfe);
        drive(1'b0, 1'b1, 8'h5a);
        @(posedge mclk);
        ptrLoad <= 1'b0;
        dataValid <= 1'b0;
        repeat (4) @(posedge mclk);
        test_done();
    end
endmodule : lmr_ram_mapper_test

//--- hw/lmr_frame_timer.sv
// Divider that turns the timing clock enable into phase steps
`timescale 1ns/100ps
module lmr_frame_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clkTick,
    input wire logic [2:0] phases,
    output logic phaseStep
);
    import lmr_pkg::*;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic next_phaseStep;
    logic [4:0] perPhase;
    always_comb begin
        // A frame is 24 timing ticks split evenly over the phases [R25]
        case (phases)
            3'h1: perPhase = 5'(FRAME_DIV / 2);
            3'h2: perPhase = 5'(FRAME_DIV / 4);
            3'h3: perPhase = 5'(FRAME_DIV / 6);
            default: perPhase = 5'(FRAME_DIV / 8);
        endcase
        next_cnt = cnt;
        next_phaseStep = 1'b0;
        if (clkTick) begin
            if (cnt >= perPhase - 5'h01) begin
                next_cnt = 5'h00;
                next_phaseStep = 1'b1;
            end else begin
                next_cnt = cnt + 5'h01;
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt <= 5'h00;
            phaseStep <= 1'b0;
        end else begin
            cnt <= next_cnt;
            phaseStep <= next_phaseStep;
        end
    end
endmodule : lmr_frame_timer

//--- hw/lmr_ram_mapper.sv
// Display memory, byte packing and backplane/segment drive
`timescale 1ns/100ps
module lmr_ram_mapper (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clkTick,
    input wire lmr_pkg::lmr_cfg_s cfgIn,
    input wire logic cfgLoad,
    input wire logic [7:0] dataByte,
    input wire logic dataValid,
    input wire logic [lmr_pkg::PTR_W-1:0] ptrIn,
    input wire logic ptrLoad,
    output lmr_pkg::lmr_bp_s backplane_out_top,
    output lmr_pkg::lmr_bp_s backplane_out_bot,
    output logic [lmr_pkg::COLS*lmr_pkg::LVL_W-1:0] segment_outputs,
    output logic biasBypass,
    output logic [lmr_pkg::PTR_W-1:0] dataPtr
);
    import lmr_pkg::*;

    lmr_cfg_s cfg;
    lmr_cfg_s next_cfg;
    logic [ROWS-1:0] ram [COLS];
    logic [ROWS-1:0] next_ram [COLS];
    logic [PTR_W-1:0] next_dataPtr;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic invert;
    logic next_invert;
    logic [COLS-1:0] dispReg;
    logic [COLS-1:0] next_dispReg;
    logic phaseStep;
    logic [2:0] phases;
    logic [LVL_W-1:0] segLvl [COLS];
    logic [COLS*LVL_W-1:0] next_seg;
    lmr_bp_s next_bp;
    logic next_biasBypass;
    logic [LVL_W-1:0] lvlSel;
    logic [LVL_W-1:0] lvlDesel;
    logic [3:0] step;
    logic [3:0] rowsPer;
    int col;
    int bitIdx;

    always_comb begin
        case (cfg.mode)
            MODE_STATIC: phases = 3'h1; // [R4]
            MODE_MUX2: phases = 3'h2; // [R5]
            MODE_MUX3: phases = 3'h3; // [R6]
            default: phases = 3'h4; // [R7]
        endcase
    end

    lmr_frame_timer timer (
        .mclk(mclk),
        .rst(rst),
        .clkTick(clkTick),
        .phases(phases),
        .phaseStep(phaseStep)
    );

    // Byte packing into memory and pointer advance
    always_comb begin
        next_cfg = cfgLoad ? cfgIn : cfg; // [R8] [R5]
        next_ram = ram;
        next_dataPtr = ptrLoad ? ptrIn : dataPtr;
        case (cfg.mode)
            MODE_STATIC: begin
                step = 4'h8;
                rowsPer = 4'h1;
            end
            MODE_MUX2: begin
                step = 4'h4;
                rowsPer = 4'h2;
            end
            MODE_MUX3: begin
                step = 4'h3;
                rowsPer = 4'h3;
            end
            default: begin
                step = 4'h2;
                rowsPer = 4'h4;
            end
        endcase
        col = 0;
        bitIdx = 0;
        // Stored on arrival, no wait for acknowledge [R17]
        if (dataValid && !ptrLoad) begin
            for (int b = 0; b < 8; b++) begin
                // MSB first, rows ascending within a column [R22]
                col = int'(dataPtr) + b / int'(rowsPer);
                bitIdx = b % int'(rowsPer);
                if (col < COLS) begin
                    // [R18] [R19] [R20] [R21] [R14]
                    next_ram[col][bitIdx] = dataByte[7-b];
                end
            end
            // Runs on past last column, wraps only at 8 bits; pointer tracks off-chip cascade
            next_dataPtr = dataPtr + PTR_W'(step); // [R23]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg <= CFG_RESET; // [R26]
            dataPtr <= '0;
            for (int c = 0; c < COLS; c++) begin
                ram[c] <= '0;
            end
        end else begin
            cfg <= next_cfg;
            dataPtr <= next_dataPtr;
            ram <= next_ram;
        end
    end

    // Phase sequencing and display register load
    always_comb begin
        next_phase = phase;
        next_invert = invert;
        next_dispReg = dispReg;
        if (phaseStep) begin
            // Rows scanned only up to the mode's count [R24]
            if (32'(phase) + 1 >= 32'(phases)) begin
                next_phase = 2'h0;
                next_invert = ~invert;
            end else begin
                next_phase = phase + 2'h1;
            end
            for (int c = 0; c < COLS; c++) begin
                next_dispReg[c] = ram[c][next_phase]; // [R16] [R1]
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase <= 2'h0;
            invert <= 1'b0;
            dispReg <= '0;
        end else begin
            phase <= next_phase;
            invert <= next_invert;
            dispReg <= next_dispReg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < COLS; g++) begin : gSeg
            lmr_seg_drive seg (
                .cfg(cfg),
                .invert(invert),
                .dataBit(dispReg[g]),
                .level(segLvl[g])
            );
        end
    endgenerate

    // Backplane levels per phase and bias
    always_comb begin
        if (cfg.mode == MODE_STATIC || cfg.halfBias) begin
            lvlSel = invert ? LVL_GND : LVL_FULL; // [R2] [R4]
            lvlDesel = (cfg.mode == MODE_STATIC) ? lvlSel : LVL_HALF;
        end else begin
            lvlSel = invert ? LVL_GND : LVL_FULL; // [R2]
            lvlDesel = invert ? LVL_TWOTHIRD : LVL_THIRD;
        end
        next_bp.bp0 = (phase == 2'h0) ? lvlSel : lvlDesel;
        next_bp.bp1 = (phase == 2'h1) ? lvlSel : lvlDesel;
        next_bp.bp2 = (phase == 2'h2) ? lvlSel : lvlDesel;
        next_bp.bp3 = (phase == 2'h3) ? lvlSel : lvlDesel;
        case (cfg.mode)
            MODE_STATIC: begin
                next_bp.bp1 = next_bp.bp0; // [R11]
                next_bp.bp2 = next_bp.bp0;
                next_bp.bp3 = next_bp.bp0;
            end
            MODE_MUX2: begin
                next_bp.bp2 = next_bp.bp0; // [R10]
                next_bp.bp3 = next_bp.bp1;
            end
            MODE_MUX3: next_bp.bp3 = next_bp.bp1; // [R9]
            default: next_bp.bp3 = next_bp.bp3; // [R7]
        endcase
        for (int c = 0; c < COLS; c++) begin
            next_seg[c*LVL_W +: LVL_W] = segLvl[c]; // [R13]
        end
        // Only 1:2 half bias shorts the middle divider element
        next_biasBypass = (cfg.mode == MODE_MUX2) && cfg.halfBias; // [R3]
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Reset shows full supply on all backplane and segment outputs
            backplane_out_top <= '1;
            backplane_out_bot <= '1;
            segment_outputs <= '1;
            biasBypass <= 1'b0;
        end else begin
            backplane_out_top <= next_bp; // [R12]
            backplane_out_bot <= next_bp; // [R12]
            segment_outputs <= next_seg;
            biasBypass <= next_biasBypass;
        end
    end
endmodule : lmr_ram_mapper

//--- hw/lmr_seg_drive.sv
// One segment output level from mode, bias, inversion and data bit
`timescale 1ns/100ps
module lmr_seg_drive (
    input wire lmr_pkg::lmr_cfg_s cfg,
    input wire logic invert,
    input wire logic dataBit,
    output logic [lmr_pkg::LVL_W-1:0] level
);
    import lmr_pkg::*;
    logic hi;
    always_comb begin
        // On bit drives opposite to backplane, off stays near it [R15] [R13]
        // Backplane sits at full supply while invert is low
        hi = ~dataBit ^ invert;
        if (cfg.mode == MODE_STATIC || dataBit) begin
            level = hi ? LVL_FULL : LVL_GND; // [R4]
        end else if (cfg.halfBias) begin
            level = LVL_HALF; // [R2]
        end else begin
            level = hi ? LVL_TWOTHIRD : LVL_THIRD; // [R2]
        end
    end
endmodule : lmr_seg_drive

//--- pkg/lmr_pkg.sv
// Constants and types shared by the display memory mapper
// Notes on behaviour
// R1: Display register holds data while waveforms drive
// R2: Levels per phase follow mode and bias
// R3: Half bias in 1:2 bypasses divider middle
// R4: Static uses one phase, two-level drive
// R5: 1:2 drives two phases, half or third
// R6: 1:3 multiplexes three phases per frame
// R7: 1:4 multiplexes four phases per frame
// R8: 1:3 and 1:4 also accept half bias
// R9: In 1:3 backplane 3 copies backplane 1
// R10: In 1:2 bp2 copies bp0, bp3 bp1
// R11: Static: all four backplanes identical
// R12: Each backplane appears on two pin rows
// R13: Segments follow phase and display register bit
// R14: Memory is 160 columns by 4 rows
// R15: Bit one turns element on, zero off
// R16: Row n supplies data for backplane n
// R17: Data bytes stored at once on arrival
// R18: Static: byte into row 0, eight columns
// R19: 1:2: four 2-bit words, rows 0-1
// R20: 1:3: three 3-bit words, last row-2 kept
// R21: 1:4: two 4-bit words, rows 0-3
// R22: Most significant bit first, rows ascending
// R23: Pointer advances 8, 4, 3 or 2
// R24: Scan rows by mode, 4/3/2/1 rows
// R25: Frame rate is timing clock over 24
// R26: Reset default is 1:4 with third bias
package lmr_pkg;
    localparam int COLS = 160;
    localparam int ROWS = 4;
    localparam int PTR_W = 8;
    localparam int FRAME_DIV = 24;
    localparam int PHASE_W = 2;
    // Drive level code: 0 = ground, 3 = full supply
    localparam int LVL_W = 2;
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_THIRD = 2'h1;
    localparam logic [1:0] LVL_TWOTHIRD = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;
    localparam logic [1:0] LVL_HALF = 2'h1;

    typedef enum logic [1:0] {
        MODE_STATIC, MODE_MUX2, MODE_MUX3, MODE_MUX4
    } lmr_mode_e;

    typedef struct packed {
        lmr_mode_e mode;
        logic halfBias;
    } lmr_cfg_s;

    localparam lmr_cfg_s CFG_RESET = '{mode: MODE_MUX4, halfBias: 1'b0};

    typedef struct packed {
        logic [LVL_W-1:0] bp3;
        logic [LVL_W-1:0] bp2;
        logic [LVL_W-1:0] bp1;
        logic [LVL_W-1:0] bp0;
    } lmr_bp_s;
endpackage : lmr_pkg
